// *** src/hesc_consts.svh ***
// Summary of operation
// - Power-on and the reset push-button each start a full hardware reset.
// - After any system reset execution starts from the boot PROM, not RAM.
// - system_available follows a software-written control bit.
// - Hardware reset clears system_available until software sets it again.
// - While cpu_halted is active system_available is forced inactive.
// - system_error is asserted whenever an unmasked error is detected.
// - Error sources are the integer unit, the FPU and internal checks.
// - Unmasked error halts by default; reset instead when software selects it.
// - cpu_halted mirrors the active-low halt lines of integer unit and FPU.
// - Halt comes from halt_request, a software halt or an error halt.
// - While halted, integer unit and FPU stop and timers and UARTs freeze.
`ifndef HESC_CONSTS_SVH
`define HESC_CONSTS_SVH

// ----------------------------------------
// Timing
// ----------------------------------------
`define HESC_CLK_PERIOD_PS 5000
`define HESC_RST_HOLD_NS 100
`define HESC_RST_CYCLES ((`HESC_RST_HOLD_NS * 1000 + `HESC_CLK_PERIOD_PS - 1) / `HESC_CLK_PERIOD_PS)

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define HESC_OFS_CTRL 8'h00
`define HESC_OFS_ERRMASK 8'h04
`define HESC_OFS_ERRSTAT 8'h08
`define HESC_OFS_STATUS 8'h0C
`define HESC_OFS_IRQSTAT 8'h10
`define HESC_OFS_IRQMASK 8'h14

// ----------------------------------------
// Field positions and reset values
// ----------------------------------------
`define HESC_CTRL_AVAIL 0
`define HESC_CTRL_SWHALT 1
`define HESC_CTRL_ERRRST 2
`define HESC_CTRL_BOOTEXIT 3
`define HESC_CTRL_RST 4'h0
`define HESC_ERR_RST 3'h0
`define HESC_IRQ_ERR 0
`define HESC_IRQ_HALT 1
`define HESC_IRQ_RESUME 2
`define HESC_IRQ_RST 3'h0
`define HESC_SYNC_RST 2'h1

`endif

// *** src/hesc_pkg.sv ***
package hesc_pkg;

  // Error sources, one bit each
  typedef struct packed {
    logic ctrlErr;
    logic fpuErr;
    logic intUnitErr;
  } hesc_err_t;

  typedef enum logic [1:0] {
    HESC_RST_HOLD = 2'b01,
    HESC_RST_RUN = 2'b10
  } hesc_rst_st_t;

endpackage

// *** src/hesc_sync3.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "hesc_consts.svh"

module hesc_sync3
  import hesc_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic [1:0] asyncIn,
  output var logic [1:0] syncOut
);

  logic [1:0] stage1_r;
  logic [1:0] stage2_r;
  logic [1:0] stage3_r;

  // A change counts only once stages two and three agree
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      stage1_r <= `HESC_SYNC_RST;
      stage2_r <= `HESC_SYNC_RST;
      stage3_r <= `HESC_SYNC_RST;
      syncOut <= `HESC_SYNC_RST;
    end
    else
    begin
      stage1_r <= asyncIn;
      stage2_r <= stage1_r;
      stage3_r <= stage2_r;
      for (int i = 0; i < 2; i++)
        if (stage2_r[i] == stage3_r[i])
          syncOut[i] <= stage3_r[i];
    end
  end

endmodule // hesc_sync3
`default_nettype wire

// *** src/hesc_rst_gen.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "hesc_consts.svh"

module hesc_rst_gen
  import hesc_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic trigger,
  output var logic rstActive
);

  localparam logic [7:0] HOLD_CYC = 8'(`HESC_RST_CYCLES);

  hesc_rst_st_t state_r;
  logic [7:0] count_r;

  // Power-on leaves us in HOLD, so the system sees a full reset pulse
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_r <= HESC_RST_HOLD;
      count_r <= 8'h00;
      rstActive <= 1'b1;
    end
    else if (trigger)
    begin
      state_r <= HESC_RST_HOLD;
      count_r <= 8'h00;
      rstActive <= 1'b1;
    end
    else
    begin
      unique case (state_r)
        HESC_RST_HOLD:
        begin
          count_r <= count_r + 8'h01;
          if (count_r == HOLD_CYC - 8'h01)
          begin
            state_r <= HESC_RST_RUN;
            rstActive <= 1'b0;
          end
        end
        HESC_RST_RUN:
        begin
          rstActive <= 1'b0;
        end
        default:
        begin
          state_r <= HESC_RST_HOLD;
          count_r <= 8'h00;
          rstActive <= 1'b1;
        end
      endcase
    end
  end

endmodule // hesc_rst_gen
`default_nettype wire

// *** src/hesc_top.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "hesc_consts.svh"

module hesc_top
  import hesc_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_b,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output var logic [31:0] prdata,
  output var logic pready,
  output var logic pslverr,
  // Front panel pins
  input wire logic haltRequest,
  input wire logic resetButton_b,
  // Error reports, same clock
  input wire hesc_err_t errIn,
  // Status and control outputs
  output var logic systemAvailable,
  output var logic systemError,
  output var logic cpuHalted,
  output var logic intUnitHalt_b,
  output var logic fpuHalt_b,
  output var logic freezeOut,
  output var logic bootFromProm,
  output var logic sysResetOut,
  output var logic irq
);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic regHit(input logic [7:0] addr, input logic [7:0] ofs);
    regHit = (addr == ofs);
  endfunction

  function automatic logic [2:0] w1c(input logic [2:0] cur, input logic clr,
                                     input logic [2:0] data, input logic [2:0] set);
    // Set wins over a clear in the same cycle
    w1c = (clr ? (cur & ~data) : cur) | set;
  endfunction

  // ----------------------------------------
  // Pin synchronisers and reset sequencer
  // ----------------------------------------
  logic [1:0] pinSync;
  logic haltSw;
  logic buttonPressed;
  logic rstActive;
  logic errRstReq_r;

  hesc_sync3 u_sync (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .asyncIn({haltRequest, resetButton_b}),
    .syncOut(pinSync)
  );

  assign haltSw = pinSync[1];
  assign buttonPressed = !pinSync[0];

  hesc_rst_gen u_rst (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .trigger(buttonPressed || errRstReq_r),
    .rstActive(rstActive)
  );

  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      sysResetOut <= 1'b1;
    else
      sysResetOut <= rstActive;
  end

  // ----------------------------------------
  // APB access
  // ----------------------------------------
  logic wrEn;
  logic [3:0] ctrl_r;
  logic [2:0] errMask_r;
  logic [2:0] errStat_r;
  logic [2:0] errStatNxt;
  logic [2:0] errSet;
  logic [2:0] irqStat_r;
  logic [2:0] irqStatNxt;
  logic [2:0] irqMask_r;
  logic [2:0] irqSet;
  logic haltNxt;
  logic mapped;
  logic [31:0] rdNxt;

  assign wrEn = psel && penable && pwrite && pready;

  always_comb
  begin
    mapped = 1'b1;
    rdNxt = 32'h0000_0000;
    if (regHit(paddr, `HESC_OFS_CTRL))
      rdNxt[3:0] = ctrl_r;
    else if (regHit(paddr, `HESC_OFS_ERRMASK))
      rdNxt[2:0] = errMask_r;
    else if (regHit(paddr, `HESC_OFS_ERRSTAT))
      rdNxt[2:0] = errStat_r;
    else if (regHit(paddr, `HESC_OFS_STATUS))
      rdNxt[4:0] = {bootFromProm, haltSw, cpuHalted, systemError, systemAvailable};
    else if (regHit(paddr, `HESC_OFS_IRQSTAT))
      rdNxt[2:0] = irqStat_r;
    else if (regHit(paddr, `HESC_OFS_IRQMASK))
      rdNxt[2:0] = irqMask_r;
    else
      mapped = 1'b0;
  end

  // Zero wait states: ready rises in the first access cycle
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end
    else
    begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !mapped;
      prdata <= (psel && !penable && !pwrite) ? rdNxt : 32'h0000_0000;
    end
  end

  // ----------------------------------------
  // Control and mask registers
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ctrl_r <= `HESC_CTRL_RST;
      errMask_r <= `HESC_ERR_RST;
      irqMask_r <= `HESC_IRQ_RST;
    end
    else if (rstActive)
    begin
      ctrl_r <= `HESC_CTRL_RST;
      errMask_r <= `HESC_ERR_RST;
      irqMask_r <= `HESC_IRQ_RST;
    end
    else if (wrEn)
    begin
      if (regHit(paddr, `HESC_OFS_CTRL))
        ctrl_r <= pwdata[3:0];
      if (regHit(paddr, `HESC_OFS_ERRMASK))
        errMask_r <= pwdata[2:0];
      if (regHit(paddr, `HESC_OFS_IRQMASK))
        irqMask_r <= pwdata[2:0];
    end
  end

  // Boot region select; software leaves the PROM once code sits in RAM
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      bootFromProm <= 1'b1;
    else if (rstActive)
      bootFromProm <= 1'b1;
    else if (wrEn && regHit(paddr, `HESC_OFS_CTRL) && pwdata[`HESC_CTRL_BOOTEXIT])
      bootFromProm <= 1'b0;
  end

  // ----------------------------------------
  // Error detection
  // ----------------------------------------
  always_comb
  begin
    errSet = errIn & ~errMask_r;
    errStatNxt = w1c(errStat_r, wrEn && regHit(paddr, `HESC_OFS_ERRSTAT), pwdata[2:0], errSet);
  end

  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      errStat_r <= `HESC_ERR_RST;
      systemError <= 1'b0;
      errRstReq_r <= 1'b0;
    end
    else if (rstActive)
    begin
      errStat_r <= `HESC_ERR_RST;
      systemError <= 1'b0;
      errRstReq_r <= 1'b0;
    end
    else
    begin
      errStat_r <= errStatNxt;
      systemError <= |errStatNxt;
      // Reset response replaces the error halt
      errRstReq_r <= (|errStatNxt) && ctrl_r[`HESC_CTRL_ERRRST];
    end
  end

  // ----------------------------------------
  // Halt and availability
  // ----------------------------------------
  // The switch is level sensitive: halt lasts as long as it is held, if held for two cycles or more
  assign haltNxt = !rstActive && (haltSw || ctrl_r[`HESC_CTRL_SWHALT] ||
                   ((|errStat_r) && !ctrl_r[`HESC_CTRL_ERRRST]));

  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cpuHalted <= 1'b0;
      intUnitHalt_b <= 1'b1;
      fpuHalt_b <= 1'b1;
      freezeOut <= 1'b0;
    end
    else
    begin
      cpuHalted <= haltNxt;
      intUnitHalt_b <= !haltNxt;
      fpuHalt_b <= !haltNxt;
      freezeOut <= haltNxt;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      systemAvailable <= 1'b0;
    else
      systemAvailable <= ctrl_r[`HESC_CTRL_AVAIL] && !haltNxt && !rstActive;
  end

  // ----------------------------------------
  // Interrupts
  // ----------------------------------------
  always_comb
  begin
    irqSet[`HESC_IRQ_ERR] = |(errSet & ~errStat_r);
    irqSet[`HESC_IRQ_HALT] = haltNxt && !cpuHalted;
    irqSet[`HESC_IRQ_RESUME] = !haltNxt && cpuHalted;
    irqStatNxt = w1c(irqStat_r, wrEn && regHit(paddr, `HESC_OFS_IRQSTAT), pwdata[2:0], irqSet);
  end

  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      irqStat_r <= `HESC_IRQ_RST;
      irq <= 1'b0;
    end
    else if (rstActive)
    begin
      irqStat_r <= `HESC_IRQ_RST;
      irq <= 1'b0;
    end
    else
    begin
      irqStat_r <= irqStatNxt;
      irq <= |(irqStatNxt & irqMask_r);
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_b);

  sequence errReset_s;
    (|errSet) && ctrl_r[`HESC_CTRL_ERRRST] && !rstActive;
  endsequence

  sequence availWrite_s;
    wrEn && regHit(paddr, `HESC_OFS_CTRL) && pwdata[`HESC_CTRL_AVAIL] && !rstActive;
  endsequence

  button_reset_a: assert property (buttonPressed |=> rstActive ##1 sysResetOut)
    else $error("reset button did not start a reset");
  boot_prom_a: assert property (rstActive |=> bootFromProm && !systemAvailable)
    else $error("reset left boot region or availability wrong");
  avail_write_a: assert property (availWrite_s ##1 (!haltNxt && !rstActive) |=> systemAvailable)
    else $error("availability did not follow software");
  avail_forced_a: assert property (haltNxt |=> cpuHalted && !systemAvailable)
    else $error("availability shown while halted");
  error_out_a: assert property (((|errSet) && !rstActive) |=> systemError && (|errStat_r))
    else $error("unmasked error not reported");
  masked_err_a: assert property ((errIn.fpuErr && errMask_r[1] && !errStat_r[1]) |=> !errStat_r[1])
    else $error("masked error latched");
  error_halt_a: assert property ((systemError && !ctrl_r[`HESC_CTRL_ERRRST] && !rstActive) |=> cpuHalted)
    else $error("error did not halt");
  error_reset_a: assert property (errReset_s |=> ##1 rstActive)
    else $error("error reset response missing");
  halt_mirror_a: assert property (cpuHalted == !intUnitHalt_b && cpuHalted == !fpuHalt_b)
    else $error("halt indication differs from halt lines");
  switch_halt_a: assert property ((haltSw && !rstActive) |=> cpuHalted && freezeOut)
    else $error("halt request ignored");
  halt_release_a: assert property ((!haltNxt) |=> !cpuHalted && intUnitHalt_b && fpuHalt_b && !freezeOut)
    else $error("halt not released");

endmodule // hesc_top
`default_nettype wire

// *** bench/hesc_cpu_model.sv ***
`timescale 1ns/1ps
`default_nettype none

module hesc_cpu_model
  import hesc_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic intUnitHalt_b,
  input wire logic fpuHalt_b,
  input wire logic [2:0] errCmd,
  output var hesc_err_t errIn,
  output var logic [15:0] progress
);
  // Execution advances only while neither halt line is low
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      progress <= 16'h0000;
    else if (intUnitHalt_b && fpuHalt_b)
      progress <= progress + 16'h0001;
  end

  // Error reports copy errCmd, registered one cycle late
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      errIn <= '0;
    else
      errIn <= errCmd;
  end
endmodule // hesc_cpu_model

`default_nettype wire

// *** bench/hesc_top_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "hesc_consts.svh"

module hesc_top_tb
  import hesc_pkg::*;
;
  logic core_clk = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0;
  logic haltRequest = 0, resetButton_b = 1;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rnd;
  logic [2:0] errCmd = 3'h0;
  hesc_err_t errIn;
  logic pready, pslverr, systemAvailable, systemError, cpuHalted, intUnitHalt_b, fpuHalt_b;
  logic freezeOut, bootFromProm, sysResetOut, irq;
  logic [15:0] progress, snap;
  logic [32:0] expQ[$];
  logic [32:0] e;
  int errCount = 0, totalChecks = 0, seed = 25371;

  always #2.5 core_clk = ~core_clk;

  hesc_top i_dut (.core_clk(core_clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .haltRequest(haltRequest), .resetButton_b(resetButton_b), .errIn(errIn),
    .systemAvailable(systemAvailable), .systemError(systemError), .cpuHalted(cpuHalted),
    .intUnitHalt_b(intUnitHalt_b), .fpuHalt_b(fpuHalt_b), .freezeOut(freezeOut),
    .bootFromProm(bootFromProm), .sysResetOut(sysResetOut), .irq(irq));

  hesc_cpu_model i_cpu (.core_clk(core_clk), .rst_b(rst_b), .intUnitHalt_b(intUnitHalt_b),
    .fpuHalt_b(fpuHalt_b), .errCmd(errCmd), .errIn(errIn), .progress(progress));

  // ----
  // Checking
  // ----
  task automatic completeRun;
    $display("checks %0d mismatches %0d", totalChecks, errCount);
    if (errCount == 0 && totalChecks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    totalChecks++;
    if (got !== exp)
    begin
      errCount++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // Every completed transfer takes the oldest expectation off the queue
  always @(posedge core_clk)
  begin
    if (psel && penable && pready)
    begin
      if (expQ.size() == 0)
        chk("queue", 0, 1);
      else
      begin
        e = expQ.pop_front();
        chk("pslverr", {31'h0, e[32]}, {31'h0, pslverr});
        if (!pwrite)
          chk("prdata", e[31:0], prdata);
      end
    end
  end

  // ----
  // Drivers
  // ----
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [32:0] exp);
    int n;
    expQ.push_back(exp);
    @(posedge core_clk);
    psel <= 1;
    penable <= 0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1;
    n = 0;
    do
    begin
      @(posedge core_clk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    psel <= 0;
    penable <= 0;
    chk("apbwait", 0, {31'h0, n >= 50});
    if (n >= 50)
      completeRun();
  endtask

  // Sel: 0 halted, 1 error, 2 system reset, 3 available
  task automatic waitLvl(input int s, input logic v);
    int n;
    logic x;
    x = ~v;
    for (n = 0; n < 200 && x !== v; n++)
    begin
      @(posedge core_clk);
      case (s)
        0: x = cpuHalted;
        1: x = systemError;
        2: x = sysResetOut;
        default: x = systemAvailable;
      endcase
    end
    chk("wait", {31'h0, v}, {31'h0, x});
    if (x !== v)
      completeRun();
  endtask

  task automatic pulse(input logic [2:0] m);
    @(posedge core_clk);
    errCmd <= m;
    @(posedge core_clk);
    errCmd <= 3'h0;
  endtask

  initial
  begin
    repeat (2) @(posedge core_clk);
    rst_b <= 1;
    waitLvl(2, 0);
    chk("boot", 1, bootFromProm);
    chk("avail", 0, systemAvailable);
    apb(0, `HESC_OFS_CTRL, 0, 0);
    rnd = $random(seed);
    apb(1, `HESC_OFS_ERRMASK, rnd, 0);
    apb(0, `HESC_OFS_ERRMASK, 0, {30'h0, rnd[2:0]});
    apb(1, `HESC_OFS_ERRMASK, 0, 0);
    apb(1, `HESC_OFS_IRQMASK, 32'h0000_0007, 0);
    apb(1, `HESC_OFS_CTRL, 32'h0000_0009, 0);
    waitLvl(3, 1);
    chk("boot", 0, bootFromProm);
    apb(0, `HESC_OFS_STATUS, 0, 33'h0_0000_0001);
    haltRequest <= 1;
    waitLvl(0, 1);
    chk("iuHalt", 0, intUnitHalt_b);
    chk("fpuHalt", 0, fpuHalt_b);
    chk("freeze", 1, freezeOut);
    chk("avail", 0, systemAvailable);
    snap = progress;
    repeat (5) @(posedge core_clk);
    chk("frozen", snap, progress);
    haltRequest <= 0;
    waitLvl(0, 0);
    chk("avail", 1, systemAvailable);
    repeat (2) @(posedge core_clk);
    chk("resumed", 1, progress != snap);
    apb(1, `HESC_OFS_CTRL, 32'h0000_000B, 0);
    waitLvl(0, 1);
    chk("avail", 0, systemAvailable);
    apb(1, `HESC_OFS_CTRL, 32'h0000_0009, 0);
    waitLvl(0, 0);
    // Both halts left halt-entered and halt-left pending; the mask must gate them
    apb(0, `HESC_OFS_IRQSTAT, 0, 33'h0_0000_0006);
    apb(1, `HESC_OFS_IRQMASK, 0, 0);
    repeat (2) @(posedge core_clk);
    chk("irqMasked", 0, irq);
    apb(1, `HESC_OFS_IRQMASK, 32'h0000_0007, 0);
    repeat (2) @(posedge core_clk);
    chk("irqUnmasked", 1, irq);
    apb(1, `HESC_OFS_IRQSTAT, 32'h0000_0007, 0);
    for (int i = 0; i < 3; i++)
    begin
      pulse(3'b001 << i);
      waitLvl(1, 1);
      waitLvl(0, 1);
      apb(0, `HESC_OFS_ERRSTAT, 0, 33'h1 << i);
      chk("irq", 1, irq);
      apb(1, `HESC_OFS_ERRSTAT, 32'h0000_0007, 0);
      waitLvl(0, 0);
      chk("system_error", 0, systemError);
      apb(1, `HESC_OFS_IRQSTAT, 32'h0000_0007, 0);
      repeat (3) @(posedge core_clk);
      chk("irq", 0, irq);
    end
    // Masked sources must leave no trace
    apb(1, `HESC_OFS_ERRMASK, 32'h0000_0007, 0);
    pulse(3'h7);
    repeat (4) @(posedge core_clk);
    chk("system_error", 0, systemError);
    chk("halted", 0, cpuHalted);
    apb(0, `HESC_OFS_ERRSTAT, 0, 0);
    apb(1, `HESC_OFS_ERRMASK, 0, 0);
    apb(1, `HESC_OFS_CTRL, 32'h0000_000D, 0);
    pulse(3'h1);
    waitLvl(2, 1);
    waitLvl(2, 0);
    chk("boot", 1, bootFromProm);
    chk("avail", 0, systemAvailable);
    apb(0, `HESC_OFS_CTRL, 0, 0);
    apb(1, `HESC_OFS_CTRL, 32'h0000_0009, 0);
    waitLvl(3, 1);
    resetButton_b <= 0;
    waitLvl(2, 1);
    resetButton_b <= 1;
    waitLvl(2, 0);
    chk("avail", 0, systemAvailable);
    chk("boot", 1, bootFromProm);
    apb(0, 8'h18, 0, 33'h1_0000_0000);
    apb(1, 8'h1C, rnd, 33'h1_0000_0000);
    completeRun();
  end
endmodule // hesc_top_tb

`default_nettype wire
